/* src/adc_parallel_conversion_port.sv */
// Parallel host port of a multichannel converter with AXI4-Lite register access
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "adc_port_defs.svh"
module adc_parallel_conversion_port #(
  parameter int RES_BITS = 12
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        convert_start_n,
  input  wire logic        master_clock_in,
  input  wire logic        chip_select_n,
  input  wire logic        read_n,
  input  wire logic        write_n,
  input  wire logic        word_byte_sel,
  input  wire logic [11:0] data_in,
  output logic      [11:0] data_out,
  output logic             data_oe,
  output logic             busy,
  output logic             track_mode,
  output logic             powered,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // Two-stage synchronisers for all pin inputs
  // Left running through reset so the edge detectors hold the real pin levels at release;
  // a fixed reset value would fake a start edge when the host idles start low
  logic [6:0]  pin_meta;
  logic [6:0]  pin_sync;
  logic [6:0]  pin_prev;
  logic [11:0] din_meta;
  logic [11:0] din_sync;
  always_ff @(posedge aclk) begin
    pin_meta <= {convert_start_n, master_clock_in, chip_select_n, read_n, write_n, word_byte_sel, data_in[8]};
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
    din_meta <= data_in;
    din_sync <= din_meta;
  end

  logic start_s;
  logic start_fall;
  logic start_rise;
  logic mclk_rise;
  logic mclk_fall;
  logic rd_active;
  logic wr_strobe_s;
  logic wr_rise;
  logic word_mode;
  logic hbe;
  assign start_s     = pin_sync[6];
  assign start_fall  = pin_prev[6] & ~pin_sync[6];
  assign start_rise  = ~pin_prev[6] & pin_sync[6];
  assign mclk_rise   = ~pin_prev[5] & pin_sync[5];
  assign mclk_fall   = pin_prev[5] & ~pin_sync[5];
  assign rd_active   = ~pin_sync[4] & ~pin_sync[3];
  assign wr_strobe_s = pin_sync[4] | pin_sync[2];
  assign wr_rise     = wr_strobe_s & ~(pin_prev[4] | pin_prev[2]);
  assign word_mode   = pin_sync[1];
  assign hbe         = pin_sync[0];

  // Control register, conversion state and result
  logic [11:0] ctrl;
  logic [1:0]  pm;
  adc_port_pkg::conv_state_type state;
  logic [3:0]  rise_cnt;
  logic [3:0]  fall_cnt;
  logic [11:0] result;
  logic [1:0]  result_chan;
  logic [1:0]  conv_chan;
  logic [11:0] sample_in;
  logic        done_ev;
  logic        res_load;
  logic        axi_wr;
  logic [11:0] axi_wval;
  assign pm = {ctrl[`PM_HI_POS], ctrl[`PM_LO_POS]};
  // Sample value comes from the port data register in this digital model
  logic [11:0] sample_src;

  // Pin writes to the control word; AXI write to the control offset also lands here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTRL_RESET;
    end else if (axi_wr) begin
      ctrl <= axi_wval;
    end else if (wr_rise) begin
      if (word_mode) begin
        ctrl <= din_sync;
      end else if (!hbe) begin
        ctrl[7:0] <= din_sync[7:0];
      end else begin
        ctrl[11:8] <= din_sync[3:0];
      end
    end
  end

  // Conversion sequencing counted in master clock edges
  assign done_ev = (state == adc_port_pkg::st_conv) && mclk_fall && (fall_cnt == `CONV_DONE_EDGES - 4'h1);
  // A late start rise in the completing cycle still aborts, so no result is taken then
  assign res_load = done_ev && !start_rise;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= adc_port_pkg::st_idle;
      rise_cnt    <= 4'h0;
      fall_cnt    <= 4'h0;
      busy        <= 1'b0;
      track_mode  <= 1'b0;
      powered     <= 1'b1;
      result      <= 12'h000;
      result_chan <= 2'h0;
      conv_chan   <= 2'h0;
    end else begin
      case (state)
        adc_port_pkg::st_idle: begin
          if (start_rise) begin
            track_mode <= 1'b1;
          end
          if (start_fall && powered) begin
            state      <= adc_port_pkg::st_conv;
            busy       <= 1'b1;
            track_mode <= 1'b0;
            rise_cnt   <= 4'h0;
            fall_cnt   <= 4'h0;
            conv_chan  <= ctrl[`CHAN_LO_POS +: 2];
          end
        end
        adc_port_pkg::st_conv: begin
          if (mclk_rise && rise_cnt != `HOLD_RELEASE_EDGES) begin
            rise_cnt <= rise_cnt + 4'h1;
            if (rise_cnt == `HOLD_RELEASE_EDGES - 4'h1) begin
              track_mode <= 1'b1;
            end
          end
          if (mclk_fall) begin
            fall_cnt <= fall_cnt + 4'h1;
          end
          if (start_rise && fall_cnt != `CONV_DONE_EDGES) begin
            state      <= adc_port_pkg::st_idle;
            busy       <= 1'b0;
            track_mode <= 1'b1;
          end else if (done_ev) begin
            result      <= sample_in;
            result_chan <= conv_chan;
            busy        <= 1'b0;
            if (pm == 2'b01 || pm == 2'b10) begin
              state      <= adc_port_pkg::st_down;
              track_mode <= 1'b0;
              powered    <= 1'b0;
            end else begin
              state <= adc_port_pkg::st_idle;
            end
          end
        end
        adc_port_pkg::st_down: begin
          if (start_rise) begin
            state      <= adc_port_pkg::st_idle;
            powered    <= 1'b1;
            track_mode <= 1'b1;
          end
        end
        default: begin
          if (pm != 2'b11) begin
            state      <= adc_port_pkg::st_idle;
            powered    <= 1'b1;
            track_mode <= 1'b1;
          end
        end
      endcase
      // Full shutdown takes effect at the write that selects it, or once a running conversion ends
      if (pm == 2'b11 && state != adc_port_pkg::st_conv) begin
        state      <= adc_port_pkg::st_off;
        powered    <= 1'b0;
        track_mode <= 1'b0;
        busy       <= 1'b0;
      end
    end
  end

  // Read mux for the shared data bus; 10-bit result sits left aligned
  // New sample bypasses the result register so the bus holds it as busy falls
  logic [11:0] word_view;
  logic [11:0] res_now;
  logic [1:0]  chan_now;
  logic [11:0] next_data_out;
  always_comb begin
    res_now   = res_load ? sample_in : result;
    chan_now  = res_load ? conv_chan : result_chan;
    word_view = (RES_BITS == 12) ? res_now : {res_now[11:2], 2'b00};
    if (word_mode) begin
      next_data_out = word_view;
    end else if (hbe) begin
      next_data_out = {4'h0, 2'b00, chan_now, word_view[11:8]};
    end else begin
      next_data_out = {4'h0, word_view[7:0]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= 12'h000;
      data_oe  <= 1'b0;
    end else begin
      data_out <= next_data_out;
      data_oe  <= rd_active;
    end
  end

  // AXI4-Lite slave: write address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~s_axi_bvalid & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~s_axi_bvalid & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr[7:0] == `CTRL_OFFSET || aw_addr[7:0] == `PORT_DATA_OFFSET) ? 2'b00 : 2'b10;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign axi_wr   = aw_held && w_held && !s_axi_bvalid && aw_addr[7:0] == `CTRL_OFFSET && s_axi_wstrb != 4'h0;
  assign axi_wval = w_data[11:0];

  // Port data register feeding the converter's sample input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sample_src <= 12'h000;
    end else if (aw_held && w_held && !s_axi_bvalid && aw_addr[7:0] == `PORT_DATA_OFFSET) begin
      sample_src <= w_data[11:0];
    end
  end
  assign sample_in = sample_src;

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        if (s_axi_araddr[7:0] == `CTRL_OFFSET) begin
          s_axi_rdata <= {20'h00000, ctrl};
        end else if (s_axi_araddr[7:0] == `STATUS_OFFSET) begin
          s_axi_rdata <= {24'h000000, state, 1'b0, powered, track_mode, busy};
        end else if (s_axi_araddr[7:0] == `RESULT_OFFSET) begin
          s_axi_rdata <= {18'h00000, result_chan, result};
        end else if (s_axi_araddr[7:0] == `PORT_DATA_OFFSET) begin
          s_axi_rdata <= {20'h00000, sample_src};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  a_busy_rise:  assert property (@(posedge aclk) disable iff (!aresetn)
    (state == adc_port_pkg::st_idle && start_fall && powered) |=> busy)
    else $error("busy not raised at start");
  a_busy_fall:  assert property (@(posedge aclk) disable iff (!aresetn)
    done_ev |=> !busy)
    else $error("busy not dropped at completion");
  a_abort_track:  assert property (@(posedge aclk) disable iff (!aresetn)
    (state == adc_port_pkg::st_conv && start_rise && fall_cnt < 4'he) |=> track_mode && !busy)
    else $error("early start rise did not abort");
  a_hold_start:  assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(busy) |-> !track_mode)
    else $error("track during start of conversion");
  a_oe_gate:  assert property (@(posedge aclk) disable iff (!aresetn)
    data_oe |-> $past(rd_active))
    else $error("bus driven without select and read");
  a_high_zero:  assert property (@(posedge aclk) disable iff (!aresetn)
    ($past(!word_mode && hbe)) |-> data_out[7:6] == 2'b00)
    else $error("high byte top bits not zero");
  a_reset_normal:  assert property (@(posedge aclk)
    !aresetn |=> pm == 2'b00 && powered)
    else $error("reset did not select normal mode");
  a_auto_down:  assert property (@(posedge aclk) disable iff (!aresetn)
    (done_ev && pm == 2'b01 && !start_rise) |=> !powered && !track_mode)
    else $error("auto shutdown not entered");
  a_wake:  assert property (@(posedge aclk) disable iff (!aresetn)
    (state == adc_port_pkg::st_down && start_rise && pm != 2'b11) |=> powered ##0 track_mode)
    else $error("no wake on start rise");
  c_conv_done:  cover property (@(posedge aclk) disable iff (!aresetn) done_ev);
  c_abort:      cover property (@(posedge aclk) disable iff (!aresetn)
    state == adc_port_pkg::st_conv && start_rise);
  c_off:        cover property (@(posedge aclk) disable iff (!aresetn) state == adc_port_pkg::st_off);
  c_byte_wr:    cover property (@(posedge aclk) disable iff (!aresetn) wr_rise && !word_mode && hbe);
  c_held_read:  cover property (@(posedge aclk) disable iff (!aresetn) res_load && rd_active);
  a_held_data:  assert property (@(posedge aclk) disable iff (!aresetn)
    (res_load && word_mode) |=> !busy && data_out == word_view)
    else $error("result not on bus as busy fell");
  a_track_wait:  assert property (@(posedge aclk) disable iff (!aresetn)
    (state == adc_port_pkg::st_idle && !track_mode && !start_rise) |=> !track_mode)
    else $error("left hold without a start rise");
  a_off_entry:  assert property (@(posedge aclk) disable iff (!aresetn)
    (pm == 2'b11 && state != adc_port_pkg::st_conv) |=> !powered && !track_mode && !busy)
    else $error("full shutdown not entered");

endmodule // adc_parallel_conversion_port

/* inc/adc_port_defs.svh */
// Offsets, field positions, reset values and timing counts of the conversion port
`ifndef ADC_PORT_DEFS_SVH
`define ADC_PORT_DEFS_SVH
`define CTRL_OFFSET        32'h0000_0000
`define STATUS_OFFSET      32'h0000_0004
`define RESULT_OFFSET      32'h0000_0008
`define PORT_DATA_OFFSET   32'h0000_000c
`define CTRL_RESET         12'h000
`define PM_LO_POS          4
`define PM_HI_POS          5
`define CHAN_LO_POS        10
`define HOLD_RELEASE_EDGES 4'hd
`define CONV_DONE_EDGES    4'he
`define ACQ_TIME_NS        125
`define PWRUP_TIME_MS      10
`endif

/* inc/adc_port_pkg.sv */
// Types shared by the conversion port
package adc_port_pkg;
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_conv  = 4'b0010,
    st_down  = 4'b0100,
    st_off   = 4'b1000
  } conv_state_type;
endpackage

/* tb/adc_host_model.sv */
// Behavioural host bus master driving the converter's parallel pins
`timescale 1ns/1ps
module adc_host_model #(
  parameter int MCLK_HALF    = 4,
  parameter int ACQ_CYCLES   = 25,
  parameter int PWRUP_CYCLES = 40
) (
  input  wire logic        aclk,
  output logic             convert_start_n,
  output logic             master_clock_in,
  output logic             chip_select_n,
  output logic             read_n,
  output logic             write_n,
  output logic [11:0]      data_in,
  input  wire logic [11:0] data_out,
  input  wire logic        data_oe
);
  int mclk_cnt = 0;
  int n_rise   = 0;
  int n_fall   = 0;
  int rise0    = 0;
  int fall0    = 0;
  // Start idles low after power-on, strobes idle high
  initial begin
    convert_start_n = 1'b0;
    master_clock_in = 1'b0;
    chip_select_n   = 1'b1;
    read_n          = 1'b1;
    write_n         = 1'b1;
    data_in         = 12'h5a5;
  end
  // Free-running master clock with running edge counts
  always @(posedge aclk) begin
    mclk_cnt <= (mclk_cnt == MCLK_HALF - 1) ? 0 : mclk_cnt + 1;
    if (mclk_cnt == MCLK_HALF - 1) begin
      master_clock_in <= ~master_clock_in;
      if (master_clock_in) n_fall <= n_fall + 1;
      else n_rise <= n_rise + 1;
    end
  end
  // Combined strobe; data held past the rising edge, then inverted
  task automatic pin_write(input logic [11:0] d);
    @(posedge aclk);
    data_in <= d;
    chip_select_n <= 1'b0;
    write_n <= 1'b0;
    repeat (4) @(posedge aclk);
    chip_select_n <= 1'b1;
    write_n <= 1'b1;
    repeat (4) @(posedge aclk);
    data_in <= ~d;
    repeat (4) @(posedge aclk);
  endtask
  task automatic pin_read(input logic hbe, output logic [11:0] d, output logic on, output logic off);
    @(posedge aclk);
    data_in[8] <= hbe;
    chip_select_n <= 1'b0;
    read_n <= 1'b0;
    repeat (6) @(posedge aclk);
    d = data_out;
    on = data_oe;
    chip_select_n <= 1'b1;
    read_n <= 1'b1;
    repeat (6) @(posedge aclk);
    off = data_oe;
  endtask
  task automatic hold_read(input logic on);
    @(posedge aclk);
    chip_select_n <= ~on;
    read_n <= ~on;
  endtask
  // Waits cover acquisition and a shortened power-up to keep the run brief
  task automatic raise_start();
    @(posedge aclk);
    convert_start_n <= 1'b1;
    repeat (ACQ_CYCLES + PWRUP_CYCLES) @(posedge aclk);
  endtask
  // Fall one cycle after a master clock fall so edge counts are unambiguous
  task automatic fall_start();
    do @(posedge aclk); while (!(mclk_cnt == 0 && !master_clock_in));
    convert_start_n <= 1'b0;
    rise0 = n_rise;
    fall0 = n_fall;
  endtask
  task automatic abort_after(input int f);
    while (n_fall - fall0 < f) @(posedge aclk);
    convert_start_n <= 1'b1;
  endtask
endmodule // adc_host_model

/* tb/adc_parallel_conversion_port_bench.sv */
// Self-checking bench of the parallel conversion port
`timescale 1ns/1ps
`include "adc_port_defs.svh"
module adc_parallel_conversion_port_bench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        word_byte_sel = 1'b1;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0]  wstrb = 4'hf;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        cs_n, rd_n, wr_n, start_n, mclk, busy, track_mode, powered, data_oe;
  logic [11:0] din, dout;
  logic [1:0]  pm_tab [3] = '{2'b00, 2'b01, 2'b10};
  int          n_fail = 0;
  int          checks_done = 0;
  int          seed = 9;
  always #2.5 aclk = ~aclk;
  adc_parallel_conversion_port u_dut (.aclk(aclk), .aresetn(aresetn), .convert_start_n(start_n),
    .master_clock_in(mclk), .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n),
    .word_byte_sel(word_byte_sel), .data_in(din), .data_out(dout), .data_oe(data_oe), .busy(busy),
    .track_mode(track_mode), .powered(powered), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  adc_host_model u_host (.aclk(aclk), .convert_start_n(start_n), .master_clock_in(mclk),
    .chip_select_n(cs_n), .read_n(rd_n), .write_n(wr_n), .data_in(din), .data_out(dout),
    .data_oe(data_oe));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Each channel released on its own handshake; wait bounded by the watchdog
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    wstrb <= s;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  function automatic logic [7:0] byte_exp(input logic [11:0] s, input logic [1:0] ch, input logic hi);
    return hi ? {2'b00, ch, s[11:8]} : s[7:0];
  endfunction
  task automatic run_conv(input logic [1:0] pm, input logic bm, input logic held);
    logic [11:0] s, c, d;
    logic        on, off;
    int          t;
    s = 12'($random(seed));
    c = 12'($random(seed)) & 12'hc0f;
    c[5:4] = pm;
    word_byte_sel <= ~bm;
    if (bm) begin
      u_host.pin_write({4'h0, c[7:0]});
      u_host.pin_write({4'h1, 4'h0, c[11:8]});
    end else begin
      u_host.pin_write(c);
    end
    axi_rd(`CTRL_OFFSET);
    check(rdata[11:0], c, "control word");
    axi_wr(`PORT_DATA_OFFSET, {20'h0, s}, 4'hf);
    if (held) u_host.hold_read(1'b1);
    u_host.fall_start();
    t = 0;
    while (busy !== 1'b1 && t < 10) begin @(posedge aclk); t++; end
    check(busy, 1'b1, "busy rise");
    check(track_mode, 1'b0, "hold");
    while (track_mode !== 1'b1 && t < 400) begin @(posedge aclk); t++; end
    check(32'(u_host.n_rise - u_host.rise0), 32'd13, "track edge");
    check(busy, 1'b1, "busy held");
    while (busy !== 1'b0 && t < 400) begin @(posedge aclk); t++; end
    check(32'(u_host.n_fall - u_host.fall0), 32'd14, "done edge");
    if (held) check(dout, s, "held read");
    if (held) u_host.hold_read(1'b0);
    repeat (4) @(posedge aclk);
    check(powered, pm == 2'b00, "auto power down");
    check(track_mode, pm == 2'b00, "track after done");
    for (int h = 0; h <= int'(bm); h++) begin
      u_host.pin_read(h[0], d, on, off);
      if (bm) check(d[7:0], byte_exp(s, c[11:10], h[0]), "byte read");
      else check(d, s, "word read");
      check({on, off}, 2'b10, "bus drive");
    end
    axi_rd(`RESULT_OFFSET);
    check(rdata[13:0], {c[11:10], s}, "result channel");
    axi_rd(`CTRL_OFFSET);
    check(rdata[11:0], c, "control kept");
    u_host.raise_start();
    check({powered, track_mode}, 2'b11, "wake");
  endtask
  // Watchdog sized well above the expected few thousand cycles
  initial begin
    #100us;
    n_fail++;
    conclude();
  end
  initial begin
    logic [11:0] w;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check({busy, track_mode, powered, data_oe}, 4'h2, "reset outputs");
    axi_rd(`CTRL_OFFSET);
    check(rdata[11:0], `CTRL_RESET, "control reset");
    axi_rd(`STATUS_OFFSET);
    check(rdata, {24'h000000, adc_port_pkg::st_idle, 4'h4}, "status after reset");
    axi_rd(32'h40);
    check(rresp, 2'b10, "unmapped read");
    axi_wr(32'h44, 32'h0, 4'hf);
    check(bresp, 2'b10, "unmapped write");
    // Register path: a write with no byte lanes leaves the control word alone
    axi_wr(`CTRL_OFFSET, 32'h0000_0c03, 4'h0);
    axi_rd(`CTRL_OFFSET);
    check(rdata[11:0], `CTRL_RESET, "strobe off write");
    w = 12'($random(seed)) & 12'hc0f;
    axi_wr(`CTRL_OFFSET, {20'h0, w}, 4'hf);
    axi_rd(`CTRL_OFFSET);
    check(rdata[11:0], w, "register write");
    u_host.raise_start();
    check(track_mode, 1'b1, "first rise");
    // Early rise aborts and returns to track
    u_host.fall_start();
    u_host.abort_after(5);
    repeat (6) @(posedge aclk);
    check({busy, track_mode}, 2'b01, "abort");
    for (int i = 0; i < 6; i++) run_conv(pm_tab[i % 3], i >= 3, i == 0);
    word_byte_sel <= 1'b1;
    u_host.pin_write(12'h030);
    repeat (4) @(posedge aclk);
    check({powered, track_mode}, 2'b00, "full shutdown");
    u_host.pin_write(12'h000);
    repeat (4) @(posedge aclk);
    check({powered, track_mode}, 2'b11, "shutdown exit");
    conclude();
  end
endmodule // adc_parallel_conversion_port_bench
